// [verilog/lpc_target_cycle_filter.sv]
`timescale 1ns/1ps
`include "lpc_filter_params.svh"

module lpc_target_cycle_filter #(
  parameter int DENSITY_MBIT = 4
) (
  input  wire logic                       ref_clk,           // system clock
  input  wire logic                       rst,               // sync reset
  input  wire logic                       lpc_clk_pin,       // host bus clock pin
  input  wire logic                       lframe_n_pin,      // frame, low active
  input  wire lpc_filter_pkg::nibble_t    lad_pin,           // bus nibble lines
  input  wire lpc_filter_pkg::nibble_t    strap_select_pins, // device straps
  input  wire logic                       flash_busy,        // erase/program running
  input  wire logic                       cycle_done,        // sequencer ended cycle
  output logic                            cycle_claim_ff,    // cycle owned, may drive
  output logic                            claim_pulse_ff,    // one-cycle claim event
  output logic                            array_sel_ff,      // 1 array, 0 registers
  output logic                            write_cycle_ff,    // claimed cycle writes
  output logic                            fwm_cycle_ff,      // firmware-memory type
  output lpc_filter_pkg::dev_addr_t       dev_addr_ff,       // device offset
  output logic                            read_ones_ff,      // answer FFH, drop write
  output logic                            write_inhibit_ff   // do not execute write
);
  import lpc_filter_pkg::*;

  // pin synchroniser: three stages, value counts when stages two and three agree
  logic [9:0] sync1_ff;
  logic [9:0] sync2_ff;
  logic [9:0] sync3_ff;
  logic [9:0] filt_ff;
  logic [9:0] nxt_filt;
  logic       clk_prev_ff;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync1_ff <= 10'h3FF;
      sync2_ff <= 10'h3FF;
      sync3_ff <= 10'h3FF;
    end else begin
      sync1_ff <= {lpc_clk_pin, lframe_n_pin, lad_pin, strap_select_pins};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  always_comb begin
    for (int i = 0; i < 10; i++)
      nxt_filt[i] = (sync2_ff[i] == sync3_ff[i]) ? sync3_ff[i] : filt_ff[i];
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      filt_ff     <= 10'h3FF;
      clk_prev_ff <= 1'b1;
    end else begin
      filt_ff     <= nxt_filt;
      clk_prev_ff <= filt_ff[9];
    end
  end

  // the host changes fields on its falling edge, so rising edge samples are stable
  logic    bus_edge;
  logic    frame_low;
  nibble_t lad_s;
  nibble_t strap_s;

  assign bus_edge  = filt_ff[9] && !clk_prev_ff;
  assign frame_low = !filt_ff[8];
  assign lad_s     = filt_ff[7:4];
  assign strap_s   = filt_ff[3:0];

  // field sequencer
  filt_state_t state_ff;
  nibble_t     start_ff;
  logic [3:0]  nib_cnt_ff;
  bus_addr_t   addr_ff;
  logic        fwm_ff;
  logic        dir_ff;

  bus_addr_t   addr_full;
  bus_addr_t   dec_addr;
  dev_addr_t   dec_dev_addr;
  logic        dec_hit;
  logic        dec_array;
  logic        dec_ones;
  logic        last_nib;
  logic        claim_now;

  assign addr_full = {addr_ff[27:0], lad_s};
  assign dec_addr  = fwm_ff ? {4'h0, addr_ff[23:0], lad_s} : addr_full;
  assign last_nib  = (state_ff == S_ADDR) && (nib_cnt_ff == 4'h1);

  addr_window_decode #(
    .DENSITY_MBIT (DENSITY_MBIT)
  ) u_decode (
    .addr      (state_ff == S_SIZE ? addr_ff : dec_addr),
    .fwm_cycle (fwm_ff),
    .strap     (strap_s),
    .dev_addr  (dec_dev_addr),
    .hit       (dec_hit),
    .to_array  (dec_array),
    .ones_only (dec_ones)
  );

  // claim on the last LPC address nibble, or on a good firmware size nibble
  assign claim_now = bus_edge && !frame_low &&
                     ((last_nib && !fwm_ff && dec_hit) ||
                      (state_ff == S_SIZE && lad_s == `FWM_SIZE_BYTE));

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_ff   <= S_IDLE;
      start_ff   <= 4'hF;
      nib_cnt_ff <= 4'h0;
      fwm_ff     <= 1'b0;
      dir_ff     <= 1'b0;
    end else if (state_ff == S_CLAIM && cycle_done) begin
      state_ff <= S_IDLE;
    end else if (bus_edge) begin
      if (frame_low) begin
        // frame low on any bus edge restarts, unless cycle_done ends a claim that cycle; only the last start nibble counts
        state_ff <= S_START;
        start_ff <= lad_s;
      end else begin
        case (state_ff)
          S_START: begin
            if (start_ff == `START_LPC_MEM && lad_s[3:2] == `CYC_MEM_TYPE) begin
              state_ff   <= S_ADDR;
              nib_cnt_ff <= `LPC_ADDR_NIBBLES;
              fwm_ff     <= 1'b0;
              dir_ff     <= lad_s[`CYC_DIR_BIT];
            end else if ((start_ff == `START_FWM_READ ||
                          start_ff == `START_FWM_WRITE) && lad_s == strap_s) begin
              state_ff   <= S_ADDR;
              nib_cnt_ff <= `FWM_ADDR_NIBBLES;
              fwm_ff     <= 1'b1;
              dir_ff     <= (start_ff == `START_FWM_WRITE);
            end else begin
              state_ff <= S_IGNORE;
            end
          end
          S_ADDR: begin
            nib_cnt_ff <= nib_cnt_ff - 4'h1;
            if (nib_cnt_ff == 4'h1) begin
              if (fwm_ff)
                state_ff <= S_SIZE;
              else if (dec_hit)
                state_ff <= S_CLAIM;
              else
                state_ff <= S_IGNORE;
            end
          end
          S_SIZE: begin
            if (lad_s == `FWM_SIZE_BYTE)
              state_ff <= S_CLAIM;
            else
              state_ff <= S_IGNORE;
          end
          S_CLAIM:  state_ff <= S_CLAIM;
          S_IGNORE: state_ff <= S_IGNORE;
          default:  state_ff <= S_IDLE;
        endcase
      end
    end
  end

  // address assembly, most significant nibble first
  always_ff @(posedge ref_clk) begin
    if (rst)
      addr_ff <= 32'h00000000;
    else if (bus_edge && !frame_low && state_ff == S_ADDR)
      addr_ff <= addr_full;
  end

  // bus ownership: only a claimed cycle may let the responder drive the lines
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cycle_claim_ff <= 1'b0;
      claim_pulse_ff <= 1'b0;
    end else begin
      claim_pulse_ff <= claim_now;
      if (claim_now)
        cycle_claim_ff <= 1'b1;
      else if (state_ff != S_CLAIM || cycle_done || (bus_edge && frame_low))
        cycle_claim_ff <= 1'b0;
    end
  end

  // attributes of the claimed cycle, held for the whole cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      array_sel_ff   <= 1'b0;
      write_cycle_ff <= 1'b0;
      fwm_cycle_ff   <= 1'b0;
      dev_addr_ff    <= 19'h00000;
      read_ones_ff   <= 1'b0;
    end else if (claim_now) begin
      array_sel_ff   <= dec_array;
      write_cycle_ff <= dir_ff;
      fwm_cycle_ff   <= fwm_ff;
      dev_addr_ff    <= dec_dev_addr;
      read_ones_ff   <= dec_ones;
    end
  end

  // busy status is sampled at claim: a write already running keeps going
  always_ff @(posedge ref_clk) begin
    if (rst)
      write_inhibit_ff <= 1'b0;
    else if (claim_now)
      write_inhibit_ff <= dir_ff && (flash_busy || dec_ones);
  end

  // checks
  sequence s_fwm_select_bad;
    bus_edge && !frame_low && state_ff == S_START &&
    (start_ff == `START_FWM_READ || start_ff == `START_FWM_WRITE) && lad_s != strap_s;
  endsequence

  sequence s_size_bad;
    bus_edge && !frame_low && state_ff == S_SIZE && lad_s != `FWM_SIZE_BYTE;
  endsequence

  chk_select_mismatch: assert property (@(posedge ref_clk) disable iff (rst)
    s_fwm_select_bad |=> state_ff == S_IGNORE ##1 !claim_pulse_ff)
    else $error("foreign device select not ignored");

  chk_size_drop: assert property (@(posedge ref_clk) disable iff (rst)
    s_size_bad |=> !cycle_claim_ff && !claim_pulse_ff)
    else $error("bad size field claimed");

  chk_ignored_quiet: assert property (@(posedge ref_clk) disable iff (rst)
    state_ff == S_IGNORE |=> !cycle_claim_ff)
    else $error("ignored cycle owns the bus");

  chk_claim_holds: assert property (@(posedge ref_clk) disable iff (rst)
    cycle_claim_ff && state_ff == S_CLAIM && !cycle_done && !bus_edge |=> cycle_claim_ff)
    else $error("claimed cycle dropped early");

  chk_claim_pulse: assert property (@(posedge ref_clk) disable iff (rst)
    claim_pulse_ff |-> cycle_claim_ff && $past(state_ff) != S_CLAIM)
    else $error("claim pulse without ownership");

  chk_busy_write: assert property (@(posedge ref_clk) disable iff (rst)
    claim_now && dir_ff && flash_busy |=> write_inhibit_ff && write_cycle_ff)
    else $error("write not inhibited while busy");

  chk_space_select: assert property (@(posedge ref_clk) disable iff (rst)
    claim_now && !fwm_ff && !(dec_addr[31:17] == `LOW_ALIAS_PREFIX)
    |=> array_sel_ff == $past(dec_addr[`ADDR_SPACE_BIT]))
    else $error("bit 22 routing wrong");

  chk_lpc_select: assert property (@(posedge ref_clk) disable iff (rst)
    last_nib && bus_edge && !frame_low && !fwm_ff && dec_addr[31:24] == `TOP16_PREFIX &&
    strap_s != 4'h0 && ((DENSITY_MBIT == 2) ? dec_addr[21:18] : {dec_addr[23], dec_addr[21:19]})
    != ~strap_s |=> state_ff == S_IGNORE)
    else $error("select bits mismatch claimed");

  chk_boundary_ones: assert property (@(posedge ref_clk) disable iff (rst)
    claim_pulse_ff && read_ones_ff && write_cycle_ff |-> write_inhibit_ff)
    else $error("write below boundary not dropped");

endmodule : lpc_target_cycle_filter

// [inc/lpc_filter_params.svh]
`ifndef LPC_FILTER_PARAMS_SVH
`define LPC_FILTER_PARAMS_SVH

// start field codes
`define START_LPC_MEM     4'h0
`define START_FWM_READ    4'hD
`define START_FWM_WRITE   4'hE

// cycle type field: bits 3:2 select memory, bit 1 is direction
`define CYC_MEM_TYPE      2'h1
`define CYC_DIR_BIT       1

// only a single byte size is accepted
`define FWM_SIZE_BYTE     4'h0

// address nibble counts
`define FWM_ADDR_NIBBLES  4'h7
`define LPC_ADDR_NIBBLES  4'h8

// address field positions
`define ADDR_SPACE_BIT    22
`define ADDR_ID3_BIT      23

// decode window prefixes
`define TOP8_PREFIX       9'h1FF
`define TOP16_PREFIX      8'hFF
`define LOW_ALIAS_PREFIX  15'h0007

// 3 Mbit density boundary, expressed on array address bits 18:17
`define BOUNDARY_HIGH     2'h0

`endif

// [inc/lpc_filter_pkg.sv]
package lpc_filter_pkg;

  typedef enum logic [2:0] {
    S_IDLE,
    S_START,
    S_ADDR,
    S_SIZE,
    S_CLAIM,
    S_IGNORE
  } filt_state_t;

  typedef logic [3:0]  nibble_t;
  typedef logic [31:0] bus_addr_t;
  typedef logic [18:0] dev_addr_t;

endpackage : lpc_filter_pkg

// [verilog/addr_window_decode.sv]
`timescale 1ns/1ps
`include "lpc_filter_params.svh"

module addr_window_decode #(
  parameter int DENSITY_MBIT = 4
) (
  input  wire lpc_filter_pkg::bus_addr_t addr,       // assembled address
  input  wire logic                      fwm_cycle,  // firmware-memory cycle
  input  wire lpc_filter_pkg::nibble_t   strap,      // strap select value
  output lpc_filter_pkg::dev_addr_t      dev_addr,   // array/register offset
  output logic                           hit,        // inside a decode window
  output logic                           to_array,   // 1 array, 0 register space
  output logic                           ones_only   // below density boundary
);
  import lpc_filter_pkg::*;

  logic [3:0] sel_bits;
  logic       top_hit;
  logic       alias_hit;

  always_comb begin
    // small part carries select on 21:18, larger ones on 23 and 21:19
    if (DENSITY_MBIT == 2) begin
      sel_bits = addr[21:18];
      top_hit  = (addr[31:23] == `TOP8_PREFIX);
    end else begin
      sel_bits = {addr[`ADDR_ID3_BIT], addr[21:19]};
      top_hit  = (addr[31:24] == `TOP16_PREFIX);
    end
    alias_hit = (strap == 4'h0) && (addr[31:17] == `LOW_ALIAS_PREFIX);
    dev_addr  = 19'h00000;
    if (fwm_cycle) begin
      hit      = 1'b1;
      to_array = addr[`ADDR_SPACE_BIT];
      if (DENSITY_MBIT == 2)
        dev_addr = {1'b0, addr[17:0]};
      else
        dev_addr = addr[18:0];
    end else if (alias_hit) begin
      // alias reaches the topmost 128 KByte of the array
      hit      = 1'b1;
      to_array = 1'b1;
      if (DENSITY_MBIT == 2)
        dev_addr = {2'h1, addr[16:0]};
      else
        dev_addr = {2'h3, addr[16:0]};
    end else begin
      hit      = top_hit && (sel_bits == ~strap);
      to_array = addr[`ADDR_SPACE_BIT];
      if (DENSITY_MBIT == 2)
        dev_addr = {1'b0, addr[17:0]};
      else
        dev_addr = addr[18:0];
    end
    ones_only = (DENSITY_MBIT == 3) && to_array &&
                (dev_addr[18:17] == `BOUNDARY_HIGH);
  end

endmodule : addr_window_decode

// [tb/lpc_host_model.sv]
`timescale 1ns/1ps
module lpc_host_model (
  input  wire logic              ref_clk,      // system clock
  output logic                   lpc_clk_pin,  // bus clock, still between frames
  output logic                   lframe_n_pin, // frame, low active
  output lpc_filter_pkg::nibble_t lad_pin      // bus nibble lines
);
  import lpc_filter_pkg::*;

  initial begin
    lpc_clk_pin  = 1'b0;
    lframe_n_pin = 1'b1;
    lad_pin      = 4'hF;
  end

  // 4 ref_clk high and at least 5 low per bus clock keeps each bus phase long enough for the sync chain
  task automatic edge_out(input logic fr, input nibble_t nib);
    @(posedge ref_clk);
    lframe_n_pin <= fr;
    lad_pin      <= nib;
    repeat (4) @(posedge ref_clk);
    lpc_clk_pin <= 1'b1;
    repeat (4) @(posedge ref_clk);
    lpc_clk_pin <= 1'b0;
  endtask : edge_out

  task automatic frame_out(input nibble_t start, input logic [35:0] body);
    int i;
    edge_out(1'b0, start);
    for (i = 8; i >= 0; i--) begin
      edge_out(1'b1, body[4*i +: 4]);
    end
    @(posedge ref_clk);
    // pull-ups: released lines read all ones
    lad_pin <= 4'hF;
  endtask : frame_out
endmodule : lpc_host_model

// [tb/lpc_target_cycle_filter_tb_top.sv]
`timescale 1ns/1ps
module lpc_target_cycle_filter_tb_top;
  import lpc_filter_pkg::*;
  logic      ref_clk;
  logic      rst;
  logic      lpc_clk_pin;
  logic      lframe_n_pin;
  nibble_t   lad_pin;
  nibble_t   strap_select_pins;
  logic      flash_busy;
  logic      cycle_done;
  logic      cycle_claim_ff;
  logic      claim_pulse_ff;
  logic      array_sel_ff;
  logic      write_cycle_ff;
  logic      fwm_cycle_ff;
  logic      read_ones_ff;
  logic      write_inhibit_ff;
  dev_addr_t dev_addr_ff;
  logic      s_claim;
  logic      s_array;
  logic      s_write;
  logic      s_fwm;
  logic      s_ones;
  logic      s_inhibit;
  dev_addr_t s_dev_addr;
  logic [7:0] big_flags;
  logic [7:0] small_flags;
  int        bad_count;
  int        n_compared;
  int        pulse_cnt;

  lpc_target_cycle_filter #(.DENSITY_MBIT(3)) dut (
    .ref_clk(ref_clk), .rst(rst), .lpc_clk_pin(lpc_clk_pin), .lframe_n_pin(lframe_n_pin),
    .lad_pin(lad_pin), .strap_select_pins(strap_select_pins), .flash_busy(flash_busy),
    .cycle_done(cycle_done), .cycle_claim_ff(cycle_claim_ff), .claim_pulse_ff(claim_pulse_ff),
    .array_sel_ff(array_sel_ff), .write_cycle_ff(write_cycle_ff), .fwm_cycle_ff(fwm_cycle_ff),
    .dev_addr_ff(dev_addr_ff), .read_ones_ff(read_ones_ff), .write_inhibit_ff(write_inhibit_ff));

  // smaller part on the same bus, to reach the narrow decode windows
  lpc_target_cycle_filter #(.DENSITY_MBIT(2)) dut_small (
    .ref_clk(ref_clk), .rst(rst), .lpc_clk_pin(lpc_clk_pin), .lframe_n_pin(lframe_n_pin),
    .lad_pin(lad_pin), .strap_select_pins(strap_select_pins), .flash_busy(flash_busy),
    .cycle_done(cycle_done), .cycle_claim_ff(s_claim), .claim_pulse_ff(),
    .array_sel_ff(s_array), .write_cycle_ff(s_write), .fwm_cycle_ff(s_fwm),
    .dev_addr_ff(s_dev_addr), .read_ones_ff(s_ones), .write_inhibit_ff(s_inhibit));

  assign big_flags   = {2'h0, cycle_claim_ff, array_sel_ff, write_cycle_ff, fwm_cycle_ff,
                        read_ones_ff, write_inhibit_ff};
  assign small_flags = {2'h0, s_claim, s_array, s_write, s_fwm, s_ones, s_inhibit};

  lpc_host_model host (.ref_clk(ref_clk), .lpc_clk_pin(lpc_clk_pin),
    .lframe_n_pin(lframe_n_pin), .lad_pin(lad_pin));

  always #4 ref_clk = ~ref_clk;

  // counts cycles high, so a stretched pulse shows up as a wrong count
  always @(posedge ref_clk) begin
    if (claim_pulse_ff === 1'b1)
      pulse_cnt <= pulse_cnt + 1;
  end

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report

  task automatic check_flags(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_flags

  task automatic check_addr(input dev_addr_t got, input dev_addr_t exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_addr

  task automatic set_inputs(input nibble_t strap, input logic busy);
    @(posedge ref_clk);
    strap_select_pins <= strap;
    flash_busy        <= busy;
    repeat (6) @(posedge ref_clk);
  endtask : set_inputs

  // attr: array, write, firmware, read ones, write inhibit
  task automatic run_cycle(input nibble_t start, input logic [35:0] body, input logic claim,
                           input logic [4:0] attr, input dev_addr_t da);
    int i;
    @(negedge ref_clk);
    pulse_cnt = 0;
    host.frame_out(start, body);
    for (i = 0; i < 16 && pulse_cnt == 0; i++) begin
      @(posedge ref_clk);
    end
    if (claim && pulse_cnt == 0) begin
      bad_count++;
      final_report();
    end
    repeat (3) @(negedge ref_clk);
    check_flags(8'(pulse_cnt), {7'h0, claim});
    if (claim) begin
      check_flags(big_flags, {3'h1, attr});
      check_addr(dev_addr_ff, da);
      @(posedge ref_clk);
      cycle_done <= 1'b1;
      @(posedge ref_clk);
      cycle_done <= 1'b0;
    end
    @(negedge ref_clk);
    check_flags({7'h0, cycle_claim_ff}, 8'h0);
  endtask : run_cycle

  task automatic sc_lpc_top;
    set_inputs(4'h0, 1'b0);
    run_cycle(4'h0, {4'h4, 32'hFFFF_1234}, 1'b1, 5'b10000, 19'h71234);
    run_cycle(4'h0, {4'h6, 32'hFFF8_1234}, 1'b1, 5'b11011, 19'h01234);
    run_cycle(4'h0, {4'h4, 32'hFFF8_1234}, 1'b1, 5'b10010, 19'h01234);
  endtask : sc_lpc_top

  task automatic sc_lpc_upper_dev;
    set_inputs(4'h8, 1'b0);
    run_cycle(4'h0, {4'h6, 32'hFF3F_0100}, 1'b1, 5'b01000, 19'h70100);
    run_cycle(4'h0, {4'h4, 32'hFFFF_1234}, 1'b0, 5'h0, 19'h0);
  endtask : sc_lpc_upper_dev

  task automatic sc_lpc_refused;
    set_inputs(4'h0, 1'b0);
    run_cycle(4'h0, {4'h4, 32'hFEFF_1234}, 1'b0, 5'h0, 19'h0);
    run_cycle(4'h0, {4'h4, 32'h00FF_1234}, 1'b0, 5'h0, 19'h0);
    run_cycle(4'h0, {4'h8, 32'hFFFF_1234}, 1'b0, 5'h0, 19'h0);
    run_cycle(4'h5, {4'h4, 32'hFFFF_1234}, 1'b0, 5'h0, 19'h0);
  endtask : sc_lpc_refused

  task automatic sc_low_alias;
    set_inputs(4'h0, 1'b0);
    run_cycle(4'h0, {4'h4, 32'h000E_5678}, 1'b1, 5'b10000, 19'h65678);
    set_inputs(4'h1, 1'b0);
    run_cycle(4'h0, {4'h4, 32'h000E_5678}, 1'b0, 5'h0, 19'h0);
  endtask : sc_low_alias

  task automatic sc_firmware;
    set_inputs(4'h5, 1'b0);
    run_cycle(4'hD, {4'h5, 28'hF7C1234, 4'h0}, 1'b1, 5'b10100, 19'h41234);
    run_cycle(4'hD, {4'h5, 28'h0BC1234, 4'h0}, 1'b1, 5'b00100, 19'h41234);
    run_cycle(4'hD, {4'h4, 28'h07C1234, 4'h0}, 1'b0, 5'h0, 19'h0);
    run_cycle(4'hD, {4'h5, 28'h07C1234, 4'h1}, 1'b0, 5'h0, 19'h0);
  endtask : sc_firmware

  task automatic sc_busy_write;
    set_inputs(4'h5, 1'b1);
    run_cycle(4'hE, {4'h5, 28'h07C1234, 4'h0}, 1'b1, 5'b11101, 19'h41234);
    set_inputs(4'h5, 1'b0);
    run_cycle(4'hE, {4'h5, 28'h07C1234, 4'h0}, 1'b1, 5'b11100, 19'h41234);
  endtask : sc_busy_write

  // smaller part: its own outputs judged; attributes only when it claims
  task automatic small_cycle(input logic [35:0] body, input logic claim, input logic [4:0] attr,
                             input dev_addr_t da);
    int i;
    @(negedge ref_clk);
    host.frame_out(4'h0, body);
    for (i = 0; i < 16 && s_claim !== 1'b1; i++) begin
      @(posedge ref_clk);
    end
    repeat (2) @(negedge ref_clk);
    if (claim) begin
      check_flags(small_flags, {3'h1, attr});
      check_addr(s_dev_addr, da);
    end else begin
      check_flags({7'h0, s_claim}, 8'h0);
    end
    @(posedge ref_clk);
    cycle_done <= 1'b1;
    @(posedge ref_clk);
    cycle_done <= 1'b0;
    @(negedge ref_clk);
    check_flags({7'h0, s_claim}, 8'h0);
  endtask : small_cycle

  task automatic sc_small_part;
    set_inputs(4'h0, 1'b0);
    small_cycle({4'h4, 32'hFFFF_1234}, 1'b1, 5'b10000, 19'h31234);
    small_cycle({4'h6, 32'hFFBF_1234}, 1'b1, 5'b01000, 19'h31234);
    small_cycle({4'h4, 32'h000E_5678}, 1'b1, 5'b10000, 19'h25678);
    small_cycle({4'h4, 32'hFF7F_1234}, 1'b0, 5'h0, 19'h0);
  endtask : sc_small_part

  initial begin
    ref_clk           = 1'b0;
    rst               = 1'b1;
    strap_select_pins = 4'h0;
    flash_busy        = 1'b0;
    cycle_done        = 1'b0;
    bad_count         = 0;
    n_compared        = 0;
    pulse_cnt         = 0;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (8) @(posedge ref_clk);
    sc_lpc_top();
    sc_lpc_upper_dev();
    sc_lpc_refused();
    sc_low_alias();
    sc_firmware();
    sc_busy_write();
    sc_small_part();
    final_report();
  end

  // hang guard
  initial begin
    repeat (100000) @(posedge ref_clk);
    bad_count++;
    final_report();
  end
endmodule : lpc_target_cycle_filter_tb_top
